// ---- verilog/mls_consts.svh ----
// mls_consts.svh: widths, reset values and timing counts for the sequencer
// assumes a 100 MHz clk_sys on both ends
`ifndef MLS_CONSTS_SVH
`define MLS_CONSTS_SVH
`define MLS_NUM_INPUTS 14
`define MLS_STATE_W 8
`define MLS_OUT_W 4
`define MLS_VIS_W 2
`define MLS_USER_TERMS 48
`define MLS_TEST_TERM_LO 48
`define MLS_TEST_TERM_HI 49
`define MLS_TOP_IN_LSB 10
`define MLS_STATE_RST 8'hff
`define MLS_OUT_RST 4'hf
`define MLS_CLK_NS 10
`define MLS_PRE_SETUP_NS 8
`define MLS_PRE_SETUP_CYC (((`MLS_PRE_SETUP_NS + `MLS_CLK_NS - 1) / `MLS_CLK_NS) < 1 ? 1 : ((`MLS_PRE_SETUP_NS + `MLS_CLK_NS - 1) / `MLS_CLK_NS))
`define MLS_FMAX_MHZ 50
`define MLS_PRE_WIDTH_CYC 2
`endif

// ---- verilog/mls_pkg.sv ----
// mls_pkg.sv: types shared by both ends of the sequencer link
// assumes mls_consts.svh is on the include path
`include "mls_consts.svh"
package mls_pkg;
	typedef logic [`MLS_NUM_INPUTS-1:0] mls_inputs_t;
	typedef logic [`MLS_STATE_W-1:0] mls_state_t;
	typedef logic [`MLS_OUT_W-1:0] mls_out_t;
	typedef enum logic [1:0] {
		MLS_DRV_IDLE = 2'b00,
		MLS_DRV_PRESET = 2'b01,
		MLS_DRV_RECOVER = 2'b11,
		MLS_DRV_RUN = 2'b10
	} mls_drv_state_t;
endpackage

// ---- verilog/mls_link_if.sv ----
// mls_link_if.sv: pins between the sequencer and the system logic driving it
// assumes one clock, clk_sys, shared by both ends
`include "mls_consts.svh"
interface mls_link_if;
	import mls_pkg::*;
	mls_inputs_t primary_inputs;
	logic diag_high_volt;
	logic pre_oe;
	logic [`MLS_OUT_W+`MLS_VIS_W-1:0] pin_out;
	logic [`MLS_OUT_W+`MLS_VIS_W-1:0] pin_oe;
	modport seq (input primary_inputs, input diag_high_volt, input pre_oe,
		output pin_out, output pin_oe);
	modport drv (output primary_inputs, output diag_high_volt, output pre_oe,
		input pin_out, input pin_oe);
endinterface

// ---- verilog/mls_driver.sv ----
// mls_driver.sv: system logic end that drives inputs and preset
// assumes the sequencer samples pre_oe on clk_sys
`include "mls_consts.svh"
module mls_driver
	import mls_pkg::*;
#(
	parameter int PRE_SETUP_CYC = `MLS_PRE_SETUP_CYC
) (
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic clk_en,
	input wire logic preset_req,
	input wire logic diag_req,
	input wire logic test_loop,
	input wire mls_inputs_t user_inputs,
	output logic ready,
	output logic [`MLS_OUT_W+`MLS_VIS_W-1:0] seen_pins,
	mls_link_if.drv link
);
	mls_drv_state_t state;
	mls_drv_state_t next_state;
	logic [3:0] wait_cnt;
	mls_inputs_t in_q;
	logic pre_q;
	logic diag_q;
	wire wait_done = (wait_cnt == 4'(PRE_SETUP_CYC));
	// ------------------------------------------------------------
	// preset sequencing
	// ------------------------------------------------------------
	always_comb begin
		next_state = state;
		case (state)
			MLS_DRV_IDLE: next_state = MLS_DRV_RECOVER;
			MLS_DRV_PRESET: if (!preset_req) next_state = MLS_DRV_RECOVER;
			MLS_DRV_RECOVER: if (wait_done) next_state = MLS_DRV_RUN;
			MLS_DRV_RUN: if (preset_req) next_state = MLS_DRV_PRESET;
			default: next_state = MLS_DRV_IDLE;
		endcase
	end
	// test loop: outputs back onto top inputs, preset tied low
	wire mls_inputs_t next_in = test_loop ?
		{link.pin_out[`MLS_OUT_W+`MLS_VIS_W-1:`MLS_VIS_W], user_inputs[`MLS_TOP_IN_LSB-1:0]} :
		user_inputs;
	wire next_pre = test_loop ? 1'b0 : (next_state == MLS_DRV_PRESET);
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			state <= MLS_DRV_IDLE;
			wait_cnt <= 4'h0;
			in_q <= '0;
			pre_q <= 1'b0;
			diag_q <= 1'b0;
			ready <= 1'b0;
			seen_pins <= '0;
		end else if (clk_en) begin
			state <= next_state;
			wait_cnt <= (next_state == MLS_DRV_RECOVER && !wait_done) ? wait_cnt + 4'h1 : 4'h0;
			in_q <= next_in;
			pre_q <= next_pre;
			diag_q <= diag_req;
			ready <= (next_state == MLS_DRV_RUN);
			seen_pins <= link.pin_out & link.pin_oe;
		end
	end
	assign link.primary_inputs = in_q;
	assign link.pre_oe = pre_q;
	assign link.diag_high_volt = diag_q;
endmodule

// ---- verilog/mls_sequencer.sv ----
// mls_sequencer.sv: registered mealy logic sequencer with preset and diagnostics
// assumes inputs are synchronous to clk_sys; the array is loaded as parameters
//
// How it works
// - elevated level on first input selects diagnostics
// - diagnostics shows six hidden state bits
// - diagnostics changes pin view only
// - two factory test terms follow user terms
// - programmer removes test terms before use
// - tester loops outputs, ties preset low
// - power-up sets every register bit high
// - preset high loads registers high on each clock edge
// - driver waits setup after power-up without raising preset
// - preset released eight ns before clock
// - first rising edge after preset clocks normally
// - clock rate independent of term usage
// - array sees state bits and fourteen inputs
// - two low state bits also drive pins
// - rising-edge set/reset flip-flops
// - shared pin is preset or output control
`include "mls_consts.svh"
module mls_sequencer
	import mls_pkg::*;
#(
	parameter int NUM_TERMS = `MLS_TEST_TERM_HI + 1,
	parameter int TERM_W = `MLS_NUM_INPUTS + `MLS_STATE_W,
	parameter bit PIN_IS_OE = 1'b0,
	parameter logic [NUM_TERMS*TERM_W-1:0] AND_TRUE = '0,
	parameter logic [NUM_TERMS*TERM_W-1:0] AND_COMP = '0,
	parameter logic [NUM_TERMS*`MLS_STATE_W-1:0] SET_S = '0,
	parameter logic [NUM_TERMS*`MLS_STATE_W-1:0] RST_S = '0,
	parameter logic [NUM_TERMS*`MLS_OUT_W-1:0] SET_Q = '0,
	parameter logic [NUM_TERMS*`MLS_OUT_W-1:0] RST_Q = '0,
	parameter logic [1:0] TEST_TERMS_KEPT = 2'h3
) (
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic clk_en,
	output mls_state_t state_view,
	output mls_out_t out_view,
	mls_link_if.seq link
);
	mls_state_t state_reg;
	mls_out_t out_reg;
	mls_state_t next_state;
	mls_out_t next_out;
	logic [`MLS_OUT_W+`MLS_VIS_W-1:0] pin_q;
	logic [`MLS_OUT_W+`MLS_VIS_W-1:0] oe_q;
	logic [NUM_TERMS-1:0] term;
	// ------------------------------------------------------------
	// product terms
	// ------------------------------------------------------------
	// no chain through or-lines: each term is one flat and, so speed holds
	wire [TERM_W-1:0] array_in = {state_reg, link.primary_inputs};
	genvar t;
	generate
		for (t = 0; t < NUM_TERMS; t++) begin : g_term
			wire [TERM_W-1:0] tr = AND_TRUE[t*TERM_W +: TERM_W];
			wire [TERM_W-1:0] cm = AND_COMP[t*TERM_W +: TERM_W];
			wire hit = &((array_in | ~tr) & (~array_in | ~cm)) & |(tr | cm);
			if (t >= `MLS_USER_TERMS) begin : g_test
				// test terms stay live until the programmer clears them
				assign term[t] = hit & TEST_TERMS_KEPT[t-`MLS_USER_TERMS];
			end else begin : g_user
				assign term[t] = hit;
			end
		end
	endgenerate
	// ------------------------------------------------------------
	// set/reset sums
	// ------------------------------------------------------------
	always_comb begin
		logic [`MLS_STATE_W-1:0] ss;
		logic [`MLS_STATE_W-1:0] rs;
		logic [`MLS_OUT_W-1:0] sq;
		logic [`MLS_OUT_W-1:0] rq;
		ss = '0;
		rs = '0;
		sq = '0;
		rq = '0;
		for (int i = 0; i < NUM_TERMS; i++) begin
			if (term[i]) begin
				ss = ss | SET_S[i*`MLS_STATE_W +: `MLS_STATE_W];
				rs = rs | RST_S[i*`MLS_STATE_W +: `MLS_STATE_W];
				sq = sq | SET_Q[i*`MLS_OUT_W +: `MLS_OUT_W];
				rq = rq | RST_Q[i*`MLS_OUT_W +: `MLS_OUT_W];
			end
		end
		// s/r: set only sets, reset only clears, both sets, neither holds
		next_state = (state_reg & ~rs) | (~state_reg & ss);
		next_state = next_state ^ (state_reg & ss & rs);
		next_out = (out_reg & ~rq) | (~out_reg & sq);
		next_out = next_out ^ (out_reg & sq & rq);
	end
	// ------------------------------------------------------------
	// pin control
	// ------------------------------------------------------------
	wire preset_act = !PIN_IS_OE && link.pre_oe;
	wire pins_float = PIN_IS_OE && link.pre_oe;
	wire diag = link.diag_high_volt;
	// view mux only; state and output registers below never see diag
	wire [`MLS_OUT_W+`MLS_VIS_W-1:0] normal_pins = {out_reg, state_reg[`MLS_VIS_W-1:0]};
	wire [`MLS_OUT_W+`MLS_VIS_W-1:0] diag_pins = state_reg[`MLS_STATE_W-1:`MLS_VIS_W];
	wire [`MLS_OUT_W+`MLS_VIS_W-1:0] next_pin = diag ? diag_pins : normal_pins;
	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	// preset is sampled each edge rather than used as an async set: one clock only
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			state_reg <= `MLS_STATE_RST;
			out_reg <= `MLS_OUT_RST;
		end else if (clk_en) begin
			if (preset_act) begin
				state_reg <= `MLS_STATE_RST;
				out_reg <= `MLS_OUT_RST;
			end else begin
				state_reg <= next_state;
				out_reg <= next_out;
			end
		end
	end
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			pin_q <= {`MLS_OUT_RST, 2'h3};
			oe_q <= '1;
			state_view <= `MLS_STATE_RST;
			out_view <= `MLS_OUT_RST;
		end else if (clk_en) begin
			pin_q <= next_pin;
			oe_q <= {{`MLS_OUT_W{!pins_float}}, {`MLS_VIS_W{1'b1}}};
			state_view <= state_reg;
			out_view <= out_reg;
		end
	end
	assign link.pin_out = pin_q;
	assign link.pin_oe = oe_q;
endmodule

// ---- verif/mls_checker.sv ----
// mls_checker.sv: assertions on the pins between the two sequencer ends
// assumes preset mode; term 0 clears bit 0 on input 1, term 1 sets it on input 2
module mls_checker
	import mls_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rstn,
	input wire mls_inputs_t primary_inputs,
	input wire logic diag_high_volt,
	input wire logic pre_oe,
	input wire logic [5:0] pin_out,
	input wire logic [5:0] pin_oe
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rstn);
	wire logic quiet = !pre_oe && !diag_high_volt;
	wire logic clr_in = primary_inputs[1] && !primary_inputs[2] && quiet;
	wire logic set_in = primary_inputs[2] && !primary_inputs[1] && quiet;
	// ----------------------------------------
	// assertions
	// ----------------------------------------
	pins_reset_a: assert property ($rose(rstn) |-> pin_out == 6'h3f)
		else $error("pins not high after reset");
	preset_hold_a: assert property (pre_oe[*3] |=> pin_out == 6'h3f)
		else $error("pins not high under preset");
	pins_driven_a: assert property (pin_oe == 6'h3f)
		else $error("pin enable dropped in preset mode");
	diag_view_a: assert property (diag_high_volt[*3] |=> pin_out == 6'h3f)
		else $error("diag view not upper state bits");
	pin_map_a: assert property (!diag_high_volt[*3] |=>
		pin_out[5:3] == 3'h7 && pin_out[1] && pin_out[2] == pin_out[0])
		else $error("normal pin map wrong");
	clr_term_a: assert property (clr_in[*3] |=> !pin_out[0])
		else $error("clear term did not act");
	set_term_a: assert property (set_in[*3] |=> pin_out[0])
		else $error("set term did not act");
	first_edge_a: assert property ($fell(pre_oe) && clr_in ##1 clr_in |-> ##[1:2] !pin_out[0])
		else $error("no transition on first edge after preset");
	cover property (diag_high_volt[*3]);
	cover property ($fell(pre_oe));
	cover property (clr_in[*3]);
endmodule

// ---- verif/tb_mealy_sequencer_preset_diag.sv ----
// tb_mealy_sequencer_preset_diag.sv: both ends joined, driven through the driver end
// assumes default pin mode is preset and test terms are removed
module tb_mealy_sequencer_preset_diag;
	import mls_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_sys, rstn, preset_req, diag_req, test_loop;
	mls_inputs_t user_inputs;
	logic ready;
	logic [5:0] seen_pins;
	mls_state_t state_view;
	mls_out_t out_view;
	int n_fail = 0;
	int n_compared = 0;
	mls_link_if link();
	// ----------------------------------------
	// the two ends and the checker
	// ----------------------------------------
	mls_driver i_mls_driver (.clk_sys(clk_sys), .rstn(rstn), .clk_en(1'b1),
		.preset_req(preset_req), .diag_req(diag_req), .test_loop(test_loop),
		.user_inputs(user_inputs), .ready(ready), .seen_pins(seen_pins), .link(link));
	// term 0 clears bit 0 on input 1, term 1 sets it on input 2
	mls_sequencer #(.TEST_TERMS_KEPT(2'h0),
		.AND_TRUE(1100'({22'h4, 22'h2})), .SET_S(400'({8'h1, 8'h0})),
		.RST_S(400'(8'h1)), .SET_Q(200'({4'h1, 4'h0})), .RST_Q(200'(4'h1)))
		i_mls_sequencer (.clk_sys(clk_sys), .rstn(rstn), .clk_en(1'b1),
		.state_view(state_view), .out_view(out_view), .link(link));
	mls_checker i_mls_checker (.clk_sys(clk_sys), .rstn(rstn),
		.primary_inputs(link.primary_inputs), .diag_high_volt(link.diag_high_volt),
		.pre_oe(link.pre_oe), .pin_out(link.pin_out), .pin_oe(link.pin_oe));
	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		n_compared++;
		if (got !== exp) begin
			n_fail++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask
	// pins settle a few edges after a request crosses the driver end
	task automatic wait_pins(input logic [5:0] exp);
		int i;
		i = 0;
		while (i < 20 && link.pin_out !== exp) begin
			@(negedge clk_sys);
			i++;
		end
		chk("pins", {2'h0, exp}, {2'h0, link.pin_out});
	endtask
	task automatic summarize();
		if (n_fail == 0 && n_compared > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// ----------------------------------------
	// clock, watchdog, tests
	// ----------------------------------------
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	// tests take a few dozen cycles
	initial begin
		#20us;
		n_fail++;
		summarize();
	end
	initial begin
		int i;
		rstn = 1'b0;
		preset_req = 1'b0;
		diag_req = 1'b0;
		test_loop = 1'b0;
		user_inputs = 14'h0;
		repeat (3) @(negedge clk_sys);
		rstn = 1'b1;
		i = 0;
		while (i < 20 && ready !== 1'b1) begin
			@(negedge clk_sys);
			i++;
		end
		chk("ready", 8'h1, {7'h0, ready});
		wait_pins(6'h3f);
		chk("state", 8'hff, state_view);
		user_inputs = 14'h2;
		wait_pins(6'h3a);
		repeat (2) @(negedge clk_sys);
		chk("state", 8'hfe, state_view);
		chk("out", 8'h0e, {4'h0, out_view});
		chk("seen", 8'h3a, {2'h0, seen_pins});
		diag_req = 1'b1;
		wait_pins(6'h3f);
		diag_req = 1'b0;
		wait_pins(6'h3a);
		preset_req = 1'b1;
		wait_pins(6'h3f);
		repeat (5) @(negedge clk_sys);
		chk("state", 8'hff, state_view);
		preset_req = 1'b0;
		wait_pins(6'h3a);
		user_inputs = 14'h4;
		wait_pins(6'h3f);
		test_loop = 1'b1;
		repeat (2) @(negedge clk_sys);
		chk("loop", 8'h0f, {4'h0, link.primary_inputs[13:10]});
		chk("loop_pre", 8'h00, {7'h0, link.pre_oe});
		summarize();
	end
endmodule
